// file: design/aim_defs.svh
// Function
// - Input five digital state is input 23
// - Input six digital state is input 24
// - Input seven digital state is input 25
// - Digital state: 0 inactive, 1 active
// - Input seven: on above 4.0V, off below 3.5V
// - Resistive or voltage mode, resistive on enable
// - Eight configuration values for every input
// - Conversion curve only on physical inputs
// - Threshold has value, delay, option field
// - Two thresholds evaluated independently
// - Option bit 1 selects above or below
// - Option bit 2 sets status on or off
// - Option bits 3 and 4 ignored
// - Option bit 5 raises warning
// - Option bit 7 commands deactivation
// - Option bit 8 raises alarm
// - Option bit 11 needs breaker closed; code gates only warning and alarm on it
// - Bits 12, 13 need fuel or gas valve
// - Option bit 14 honours disable-protections inputs; code gates only warning and alarm on it
// - Option bit 15 stops fuel pump
// - Option bit 16 suppressed under override
// - Any option combination applies together
`ifndef AIM_DEFS_SVH
`define AIM_DEFS_SVH

// Register map, 0x40 bytes per input
`define AIM_INPUT_STRIDE  8'h40
`define AIM_OFS_FUNC      4'h0
`define AIM_OFS_MODE      4'h1
`define AIM_OFS_MSG       4'h2
`define AIM_OFS_THR0      4'h3
`define AIM_OFS_DLY0      4'h4
`define AIM_OFS_OPT0      4'h5
`define AIM_OFS_THR1      4'h6
`define AIM_OFS_DLY1      4'h7
`define AIM_OFS_OPT1      4'h8
`define AIM_ADDR_STATUS   8'hc0

// Function codes
`define AIM_FUNC_DIGITAL  16'h0100
`define AIM_FUNC_UNUSED   16'h0000

// Mode register fields
`define AIM_MODE_VOLT     0
`define AIM_MODE_CURVE    1

// Option fields, bit n at position n-1
`define AIM_OPT_BELOW     0
`define AIM_OPT_SET_ON    1
`define AIM_OPT_WARN      4
`define AIM_OPT_DEACT     6
`define AIM_OPT_ALARM     7
`define AIM_OPT_GCB       10
`define AIM_OPT_FUEL      11
`define AIM_OPT_GAS       12
`define AIM_OPT_DISPROT   13
`define AIM_OPT_PUMP      14
`define AIM_OPT_OVR       15

// Input seven hysteresis, millivolts
`define AIM_SEVEN_ON_MV   16'h0fa0
`define AIM_SEVEN_OFF_MV  16'h0dac

// Delay tick: one delay unit is 1 ms
`define AIM_CLK_NS        50
`define AIM_TICK_NS       1000000
`define AIM_TICK_CYCLES   (`AIM_TICK_NS / `AIM_CLK_NS)

// Bus responses
`define AIM_RESP_OKAY     2'b00
`define AIM_RESP_SLVERR   2'b10

`endif

// file: design/aim_monitor.sv
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "aim_defs.svh"

module aim_monitor
  import aim_pkg::*;
#(
  parameter int TICK_CYCLES = `AIM_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RSTN,
  // AXI4-Lite write
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // Measurements from the converter, same clock
  input  wire logic [15:0] MEAS_FIVE,
  input  wire logic [15:0] MEAS_SIX,
  input  wire logic [15:0] MEAS_SEVEN_MV,
  // Terminal levels for digital use, asynchronous
  input  wire logic        RESISTIVE_TERMINAL_FOUR_N,
  input  wire logic        RESISTIVE_TERMINAL_FIVE_N,
  // Plant qualifiers, same clock
  input  wire logic        GENERATOR_CIRCUIT_BREAKER_CLOSED,
  input  wire logic        FUEL_VALVE_ACTIVE,
  input  wire logic        GAS_VALVE_ACTIVE,
  input  wire logic        DISABLE_ANALOG_PROTECTIONS_ON,
  input  wire logic        ENGINE_PROTECTION_OVERRIDE,
  // Digital input states 23, 24, 25
  output logic [2:0]       DIG_INPUT_STATE,
  output logic [2:0]       DIG_INPUT_USED,
  // Internal status per input
  output logic [2:0]       INTERNAL_STATUS,
  // Front-end control: voltage mode for inputs five and six, curve per input
  output logic [1:0]       VOLTAGE_MODE,
  output logic [2:0]       CURVE_APPLY,
  // Actions
  output logic             WARNING,
  output logic             ALARM,
  output logic             DEACTIVATION,
  output logic             FUEL_PUMP_STOP
);

  localparam int NIN = 3;
  localparam int NTH = 6;

  // Configuration storage, eight values per input plus mode
  logic [15:0] func_reg [NIN];
  aim_mode_t   mode_reg [NIN];
  logic [31:0] msg_reg  [NIN];
  aim_meas_t   thr_reg  [NTH];
  aim_delay_t  dly_reg  [NTH];
  aim_opt_t    opt_reg  [NTH];

  // Bus state
  logic        awready_reg;
  logic        wready_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        arready_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  // Monitor state
  logic [2:0]  sync_a_reg;
  logic [2:0]  sync_b_reg;
  logic        lvl_four_reg;
  logic        lvl_five_reg;
  logic        seven_on_reg;
  logic [2:0]  dig_state_reg;
  logic [2:0]  dig_used_reg;
  logic [2:0]  int_status_reg;
  logic [1:0]  volt_mode_reg;
  logic [2:0]  curve_reg;
  logic        warn_reg;
  logic        alarm_reg;
  logic        deact_reg;
  logic        pump_reg;
  logic [14:0] tick_cnt_reg;
  logic        tick_reg;
  logic [NTH-1:0] confirmed;
  logic [NTH-1:0] warn_th;
  logic [NTH-1:0] alarm_th;
  logic [NTH-1:0] deact_th;
  logic [NTH-1:0] pump_th;
  aim_meas_t   meas [NIN];
  logic [NIN-1:0] analog_use;

  // Write decode
  logic        wr_fire;
  logic [1:0]  wr_in;
  logic [3:0]  wr_ofs;
  logic        wr_hit;
  logic [31:0] wr_mask;

  assign meas[0] = MEAS_FIVE;
  assign meas[1] = MEAS_SIX;
  assign meas[2] = MEAS_SEVEN_MV;

  assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
  assign wr_in   = awaddr_reg[7:6];
  assign wr_ofs  = awaddr_reg[5:2];
  assign wr_hit  = (wr_in != 2'd3) && (wr_ofs <= `AIM_OFS_OPT1);
  assign wr_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

  function automatic logic [15:0] merge(input logic [15:0] old);
    merge = (old & ~wr_mask[15:0]) | (wdata_reg[15:0] & wr_mask[15:0]);
  endfunction : merge

  // AW and W in either order, response after both
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `AIM_RESP_OKAY;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end else begin
      if (awready_reg && S_AXI_AWVALID) begin
        awready_reg <= 1'b0;
        awaddr_reg  <= S_AXI_AWADDR;
      end
      if (wready_reg && S_AXI_WVALID) begin
        wready_reg <= 1'b0;
        wdata_reg  <= S_AXI_WDATA;
        wstrb_reg  <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? `AIM_RESP_OKAY : `AIM_RESP_SLVERR;
      end
      if (bvalid_reg && S_AXI_BREADY) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // Per-input configuration: function, mode and message
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < NIN; i++) begin
        func_reg[i] <= `AIM_FUNC_UNUSED;
        mode_reg[i] <= 2'h0;
        msg_reg[i]  <= 32'h0000_0000;
      end
    end else if (wr_fire && wr_hit) begin
      case (wr_ofs)
        `AIM_OFS_FUNC: begin
          func_reg[wr_in] <= merge(func_reg[wr_in]);
          // Enabling from unused falls back to resistive
          if (func_reg[wr_in] == `AIM_FUNC_UNUSED) begin
            mode_reg[wr_in][`AIM_MODE_VOLT] <= 1'b0;
          end
        end
        `AIM_OFS_MODE: begin
          mode_reg[wr_in] <= 2'(merge({14'h0, mode_reg[wr_in]}));
        end
        `AIM_OFS_MSG: begin
          msg_reg[wr_in] <= (msg_reg[wr_in] & ~wr_mask) | (wdata_reg & wr_mask);
        end
        default: begin
        end
      endcase
    end
  end

  // Threshold triplets, two per input
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int t = 0; t < NTH; t++) begin
        thr_reg[t] <= 16'h0000;
        dly_reg[t] <= 16'h0000;
        opt_reg[t] <= 16'h0000;
      end
    end else if (wr_fire && wr_hit) begin
      case (wr_ofs)
        `AIM_OFS_THR0: thr_reg[2*wr_in]   <= merge(thr_reg[2*wr_in]);
        `AIM_OFS_DLY0: dly_reg[2*wr_in]   <= merge(dly_reg[2*wr_in]);
        `AIM_OFS_OPT0: opt_reg[2*wr_in]   <= merge(opt_reg[2*wr_in]);
        `AIM_OFS_THR1: thr_reg[2*wr_in+1] <= merge(thr_reg[2*wr_in+1]);
        `AIM_OFS_DLY1: dly_reg[2*wr_in+1] <= merge(dly_reg[2*wr_in+1]);
        `AIM_OFS_OPT1: opt_reg[2*wr_in+1] <= merge(opt_reg[2*wr_in+1]);
        default: begin
        end
      endcase
    end
  end

  // Read answer one cycle after the address
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `AIM_RESP_OKAY;
    end else if (arready_reg && S_AXI_ARVALID) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rresp_reg   <= `AIM_RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
      if (S_AXI_ARADDR == `AIM_ADDR_STATUS) begin
        rdata_reg <= {20'h0, confirmed, int_status_reg, dig_state_reg};
      end else if (S_AXI_ARADDR[7:6] == 2'd3 || S_AXI_ARADDR[5:2] > `AIM_OFS_OPT1) begin
        rresp_reg <= `AIM_RESP_SLVERR;
      end else begin
        case (S_AXI_ARADDR[5:2])
          `AIM_OFS_FUNC: rdata_reg <= {16'h0, func_reg[S_AXI_ARADDR[7:6]]};
          `AIM_OFS_MODE: rdata_reg <= {30'h0, mode_reg[S_AXI_ARADDR[7:6]]};
          `AIM_OFS_MSG:  rdata_reg <= msg_reg[S_AXI_ARADDR[7:6]];
          `AIM_OFS_THR0: rdata_reg <= {16'h0, thr_reg[2*S_AXI_ARADDR[7:6]]};
          `AIM_OFS_DLY0: rdata_reg <= {16'h0, dly_reg[2*S_AXI_ARADDR[7:6]]};
          `AIM_OFS_OPT0: rdata_reg <= {16'h0, opt_reg[2*S_AXI_ARADDR[7:6]]};
          `AIM_OFS_THR1: rdata_reg <= {16'h0, thr_reg[2*S_AXI_ARADDR[7:6]+1]};
          `AIM_OFS_DLY1: rdata_reg <= {16'h0, dly_reg[2*S_AXI_ARADDR[7:6]+1]};
          `AIM_OFS_OPT1: rdata_reg <= {16'h0, opt_reg[2*S_AXI_ARADDR[7:6]+1]};
          default:       rdata_reg <= 32'h0000_0000;
        endcase
      end
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // Shared delay tick
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tick_cnt_reg <= 15'h0000;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == 15'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= 15'h0000;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 15'h0001;
      tick_reg     <= 1'b0;
    end
  end

  // Terminal sync; level taken once stages two and three agree
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sync_a_reg   <= 3'b111;
      sync_b_reg   <= 3'b111;
      lvl_four_reg <= 1'b1;
      lvl_five_reg <= 1'b1;
    end else begin
      sync_a_reg <= {sync_a_reg[1:0], RESISTIVE_TERMINAL_FOUR_N};
      sync_b_reg <= {sync_b_reg[1:0], RESISTIVE_TERMINAL_FIVE_N};
      if (sync_a_reg[1] == sync_a_reg[2]) begin
        lvl_four_reg <= sync_a_reg[2];
      end
      if (sync_b_reg[1] == sync_b_reg[2]) begin
        lvl_five_reg <= sync_b_reg[2];
      end
    end
  end

  // Input seven hysteresis; between the levels the state holds
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      seven_on_reg <= 1'b0;
    end else if (MEAS_SEVEN_MV > `AIM_SEVEN_ON_MV) begin
      seven_on_reg <= 1'b1;
    end else if (MEAS_SEVEN_MV < `AIM_SEVEN_OFF_MV) begin
      seven_on_reg <= 1'b0;
    end
  end

  // Digital states, bit 0 is input 23, bit 1 is 24, bit 2 is 25
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      dig_state_reg <= 3'b000;
      dig_used_reg  <= 3'b000;
    end else begin
      for (int i = 0; i < NIN; i++) begin
        dig_used_reg[i] <= (func_reg[i] == `AIM_FUNC_DIGITAL);
      end
      // Grounding a resistive terminal makes it active
      dig_state_reg[0] <= (func_reg[0] == `AIM_FUNC_DIGITAL) && !lvl_four_reg;
      dig_state_reg[1] <= (func_reg[1] == `AIM_FUNC_DIGITAL) && !lvl_five_reg;
      dig_state_reg[2] <= (func_reg[2] == `AIM_FUNC_DIGITAL) && seven_on_reg;
    end
  end

  // Thresholds run only in analogue use
  always_comb begin
    for (int i = 0; i < NIN; i++) begin
      analog_use[i] = (func_reg[i] != `AIM_FUNC_UNUSED) && (func_reg[i] != `AIM_FUNC_DIGITAL);
    end
  end

  // One independent evaluator per threshold
  generate
    for (genvar t = 0; t < NTH; t++) begin : g_thr
      logic       above;
      logic       below;
      logic       out_now;
      logic       anomaly;
      logic       prot_ok;
      aim_delay_t held_reg;

      assign above   = meas[t/2] > thr_reg[t];
      assign below   = meas[t/2] < thr_reg[t];
      assign out_now = analog_use[t/2] && (opt_reg[t][`AIM_OPT_BELOW] ? below : above);

      // Persistence counter, cleared when back inside
      always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
          held_reg <= 16'h0000;
        end else if (!out_now) begin
          held_reg <= 16'h0000;
        end else if (tick_reg && held_reg < dly_reg[t]) begin
          held_reg <= held_reg + 16'h0001;
        end
      end

      assign confirmed[t] = out_now && (held_reg >= dly_reg[t]);

      // Bits 3 and 4 are never decoded
      assign anomaly = confirmed[t]
                       && !(opt_reg[t][`AIM_OPT_FUEL] && !FUEL_VALVE_ACTIVE)
                       && !(opt_reg[t][`AIM_OPT_GAS] && !GAS_VALVE_ACTIVE)
                       && !(opt_reg[t][`AIM_OPT_OVR] && ENGINE_PROTECTION_OVERRIDE);
      assign prot_ok = !(opt_reg[t][`AIM_OPT_GCB] && !GENERATOR_CIRCUIT_BREAKER_CLOSED)
                       && !(opt_reg[t][`AIM_OPT_DISPROT] && DISABLE_ANALOG_PROTECTIONS_ON);
      assign warn_th[t]  = anomaly && prot_ok && opt_reg[t][`AIM_OPT_WARN];
      assign alarm_th[t] = anomaly && prot_ok && opt_reg[t][`AIM_OPT_ALARM];
      assign deact_th[t] = anomaly && opt_reg[t][`AIM_OPT_DEACT];
      assign pump_th[t]  = anomaly && opt_reg[t][`AIM_OPT_PUMP];
    end
  endgenerate

  // Internal status; second threshold wins a tie
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      int_status_reg <= 3'b000;
    end else begin
      for (int i = 0; i < NIN; i++) begin
        if (confirmed[2*i+1]) begin
          int_status_reg[i] <= opt_reg[2*i+1][`AIM_OPT_SET_ON];
        end else if (confirmed[2*i]) begin
          int_status_reg[i] <= opt_reg[2*i][`AIM_OPT_SET_ON];
        end
      end
    end
  end

  // Combined actions
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      warn_reg  <= 1'b0;
      alarm_reg <= 1'b0;
      deact_reg <= 1'b0;
      pump_reg  <= 1'b0;
    end else begin
      warn_reg  <= |warn_th;
      alarm_reg <= |alarm_th;
      deact_reg <= |deact_th;
      pump_reg  <= |pump_th;
    end
  end

  // Front-end mode; input seven is voltage only
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      volt_mode_reg <= 2'b00;
      curve_reg     <= 3'b000;
    end else begin
      volt_mode_reg <= {mode_reg[1][`AIM_MODE_VOLT], mode_reg[0][`AIM_MODE_VOLT]};
      // All three are physical, so curves apply
      for (int i = 0; i < NIN; i++) begin
        curve_reg[i] <= analog_use[i] && mode_reg[i][`AIM_MODE_CURVE];
      end
    end
  end

  // Port drive
  assign S_AXI_AWREADY   = awready_reg;
  assign S_AXI_WREADY    = wready_reg;
  assign S_AXI_BVALID    = bvalid_reg;
  assign S_AXI_BRESP     = bresp_reg;
  assign S_AXI_ARREADY   = arready_reg;
  assign S_AXI_RVALID    = rvalid_reg;
  assign S_AXI_RDATA     = rdata_reg;
  assign S_AXI_RRESP     = rresp_reg;
  assign DIG_INPUT_STATE = dig_state_reg;
  assign DIG_INPUT_USED  = dig_used_reg;
  assign INTERNAL_STATUS = int_status_reg;
  assign VOLTAGE_MODE    = volt_mode_reg;
  assign CURVE_APPLY     = curve_reg;
  assign WARNING         = warn_reg;
  assign ALARM           = alarm_reg;
  assign DEACTIVATION    = deact_reg;
  assign FUEL_PUMP_STOP  = pump_reg;

endmodule : aim_monitor
`default_nettype wire

// file: design/aim_pkg.sv
package aim_pkg;
  typedef logic [15:0] aim_meas_t;
  typedef logic [15:0] aim_opt_t;
  typedef logic [15:0] aim_delay_t;
  typedef logic [1:0]  aim_mode_t;
endpackage : aim_pkg

// file: verif/aim_monitor_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "aim_defs.svh"

module aim_monitor_tb import aim_pkg::*;;
  localparam int        TICK         = 4;
  localparam aim_meas_t SEVEN_MV [8] = '{16'h1388, 16'h0e74, 16'h0bb8, 16'h0e74, `AIM_SEVEN_ON_MV,
    `AIM_SEVEN_ON_MV + 16'h1, `AIM_SEVEN_OFF_MV, `AIM_SEVEN_OFF_MV - 16'h1};
  localparam logic [7:0] SEVEN_ON    = 8'h63;
  logic        ref_clk = 1'h0, rstn = 1'h0;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic        awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic        awready, wready, bvalid, arready, rvalid, term4_n, term5_n, warn, alarm, deact, pump;
  logic [1:0]  bresp, rresp, vmode, closed = '0;
  aim_meas_t   m5 = '0, m6 = '0, m7 = '0, meas5, meas6, meas7;
  logic        slow = '0, gcb = '0, fuel = '0, gas = '0, disprot = '0, ovr = '0;
  logic [2:0]  dstate, dused, istat, curve;
  int          fail_count = 0, checked = 0, cycles = 0, seed = 32'h6dd1a19b;

  // Sensors and contacts on the far side
  aim_plant i_plant (.clk(ref_clk), .slow(slow), .five_cmd(m5), .six_cmd(m6), .seven_cmd(m7),
    .close_cmd(closed), .meas_five(meas5), .meas_six(meas6), .meas_seven_mv(meas7),
    .term_four_n(term4_n), .term_five_n(term5_n));
  aim_monitor #(.TICK_CYCLES(TICK)) i_dut (.REF_CLK(ref_clk), .RSTN(rstn), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .MEAS_FIVE(meas5), .MEAS_SIX(meas6), .MEAS_SEVEN_MV(meas7), .RESISTIVE_TERMINAL_FOUR_N(term4_n),
    .RESISTIVE_TERMINAL_FIVE_N(term5_n), .GENERATOR_CIRCUIT_BREAKER_CLOSED(gcb),
    .FUEL_VALVE_ACTIVE(fuel), .GAS_VALVE_ACTIVE(gas), .DISABLE_ANALOG_PROTECTIONS_ON(disprot),
    .ENGINE_PROTECTION_OVERRIDE(ovr), .DIG_INPUT_STATE(dstate), .DIG_INPUT_USED(dused),
    .INTERNAL_STATUS(istat), .VOLTAGE_MODE(vmode), .CURVE_APPLY(curve), .WARNING(warn),
    .ALARM(alarm), .DEACTIVATION(deact), .FUEL_PUMP_STOP(pump));

  // Clock and hang guard
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  function automatic logic [7:0] ra(int i, int ofs);
    return 8'(i * `AIM_INPUT_STRIDE + ofs * 4);
  endfunction : ra

  // AW and W together, each released once taken
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] resp = `AIM_RESP_OKAY);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    check("bresp", resp, bresp);
  endtask : wr

  task automatic rd(logic [7:0] a, logic [31:0] exp, logic [1:0] resp = `AIM_RESP_OKAY);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    check("rdata", exp, rdata);
    check("rresp", resp, rresp);
  endtask : rd

  initial begin
    aim_opt_t  opt [2];
    aim_meas_t thr [2];
    aim_meas_t m;
    logic      ew, ea, ed, ep, st, c, q, g;
    st = 1'h0;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'h1;
    // Bus basics and holes in the map
    rd(`AIM_ADDR_STATUS, '0);
    rd(8'h24, '0, `AIM_RESP_SLVERR);
    wr(8'hc4, 32'hff, `AIM_RESP_SLVERR);
    wr(ra(2, `AIM_OFS_MSG), 32'h5a5ac3c3);
    rd(ra(2, `AIM_OFS_MSG), 32'h5a5ac3c3);
    wr(ra(2, `AIM_OFS_THR1), 32'habcd1234);
    rd(ra(2, `AIM_OFS_THR1), 32'h1234);
    // Enabling drops voltage mode
    wr(ra(1, `AIM_OFS_MODE), 32'h3);
    repeat (2) @(posedge ref_clk);
    check("vmode", 1'h1, vmode[1]);
    check("curve", 1'h0, curve[1]);
    wr(ra(1, `AIM_OFS_FUNC), 32'h2051);
    repeat (2) @(posedge ref_clk);
    check("vmode", 1'h0, vmode[1]);
    check("curve", 1'h1, curve[1]);
    rd(ra(1, `AIM_OFS_MODE), 32'h2);
    // Contacts ignored until digital use
    closed <= 2'h3;
    repeat (10) @(posedge ref_clk);
    check("dstate", 2'h0, dstate[1:0]);
    wr(ra(0, `AIM_OFS_FUNC), `AIM_FUNC_DIGITAL);
    wr(ra(1, `AIM_OFS_FUNC), `AIM_FUNC_DIGITAL);
    for (int i = 0; i < 4; i++) begin
      closed <= 2'(i);
      repeat (10) @(posedge ref_clk);
      check("dstate", closed, dstate[1:0]);
      rd(`AIM_ADDR_STATUS, {30'h0, closed});
    end
    // Charger input band walk
    wr(ra(2, `AIM_OFS_FUNC), `AIM_FUNC_DIGITAL);
    for (int i = 0; i < 8; i++) begin
      m7 <= SEVEN_MV[i];
      repeat (6) @(posedge ref_clk);
      check("dstate7", SEVEN_ON[i], dstate[2]);
    end
    check("dused", 3'h7, dused);
    // Random options, input off during setup
    for (int n = 0; n < 40; n++) begin
      wr(ra(0, `AIM_OFS_FUNC), `AIM_FUNC_UNUSED);
      m = 16'($random(seed));
      m5 <= m;
      m6 <= 16'($random(seed));
      {gcb, fuel, gas, disprot, ovr, slow} <= 6'($random(seed));
      for (int k = 0; k < 2; k++) begin
        thr[k] = m + 16'($random(seed) % 2);
        opt[k] = 16'($random(seed));
        wr(ra(0, `AIM_OFS_THR0 + 3 * k), {16'h0, thr[k]});
        wr(ra(0, `AIM_OFS_OPT0 + 3 * k), {16'h0, opt[k]});
      end
      wr(ra(0, `AIM_OFS_FUNC), 32'h2051);
      repeat (8) @(posedge ref_clk);
      {ew, ea, ed, ep} = '0;
      for (int k = 0; k < 2; k++) begin
        // Option bit n sits at index n-1
        c = opt[k][0] ? m < thr[k] : m > thr[k];
        q = (!opt[k][11] || fuel) && (!opt[k][12] || gas) && (!opt[k][15] || !ovr);
        g = q && (!opt[k][10] || gcb) && (!opt[k][13] || !disprot);
        ew |= c && opt[k][4] && g;
        ea |= c && opt[k][7] && g;
        ed |= c && opt[k][6] && q;
        ep |= c && opt[k][14] && q;
        if (c) st = opt[k][1];
      end
      check("warning", ew, warn);
      check("alarm", ea, alarm);
      check("deact", ed, deact);
      check("pump", ep, pump);
      check("status", st, istat[0]);
    end
    // Delay of three units; a dip restarts it
    wr(ra(0, `AIM_OFS_FUNC), `AIM_FUNC_UNUSED);
    m5 <= 16'h0050;
    {gcb, fuel, gas, disprot, ovr, slow} <= 6'h38;
    wr(ra(0, `AIM_OFS_THR0), 32'h0100);
    wr(ra(0, `AIM_OFS_DLY0), 32'h3);
    wr(ra(0, `AIM_OFS_OPT0), 32'h0010);
    wr(ra(0, `AIM_OFS_OPT1), 32'h0);
    wr(ra(0, `AIM_OFS_FUNC), 32'h2051);
    for (int i = 0; i < 2; i++) begin
      m5 <= 16'h0200;
      repeat (8) @(posedge ref_clk);
      check("warn early", 1'h0, warn);
      repeat (10) @(posedge ref_clk);
      check("warn late", 1'h1, warn);
      m5 <= 16'h0050;
      @(posedge ref_clk);
    end
    report_and_stop();
  end
endmodule : aim_monitor_tb

`default_nettype wire

// file: verif/aim_plant.sv
`timescale 1ns/10ps
`default_nettype none

module aim_plant (
  // Bench commands
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic [15:0] five_cmd,
  input  wire logic [15:0] six_cmd,
  input  wire logic [15:0] seven_cmd,
  input  wire logic [1:0]  close_cmd,
  // Sensor and switch levels
  output logic      [15:0] meas_five,
  output logic      [15:0] meas_six,
  output logic      [15:0] meas_seven_mv,
  output logic             term_four_n,
  output logic             term_five_n
);
  wire logic [49:0] now_w   = {five_cmd, six_cmd, seven_cmd, ~close_cmd[0], ~close_cmd[1]};
  logic      [49:0] lag_reg = {48'h0, 2'h3};

  // Contacts idle at the pull-up; slow adds a cycle
  always @(posedge clk) begin
    lag_reg <= now_w;
    {meas_five, meas_six, meas_seven_mv, term_four_n, term_five_n} <= slow ? lag_reg : now_w;
  end
endmodule : aim_plant

`default_nettype wire

// file: verif/aim_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "aim_defs.svh"

module aim_props (
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        RSTN,
  // Bus handshakes
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  // Digital use of the inputs
  input wire logic [15:0] MEAS_SEVEN_MV,
  input wire logic        RESISTIVE_TERMINAL_FOUR_N,
  input wire logic        RESISTIVE_TERMINAL_FIVE_N,
  input wire logic [2:0]  DIG_INPUT_STATE,
  input wire logic [2:0]  DIG_INPUT_USED
);
  // One domain, so clock and reset are given once
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  property p_rd_answer;
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("no rvalid");
  property p_rd_hold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("rvalid dropped");
  property p_wr_answer;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("no bvalid");
  property p_wr_hold;
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("bvalid dropped");
  // Digital state settles within eight edges
  property p_dig5_on;
    (DIG_INPUT_USED[0] && !RESISTIVE_TERMINAL_FOUR_N) [*8] |-> DIG_INPUT_STATE[0];
  endproperty
  a_dig5_on: assert property (p_dig5_on) else $error("input five not active");
  property p_dig5_off;
    (DIG_INPUT_USED[0] && RESISTIVE_TERMINAL_FOUR_N) [*8] |-> !DIG_INPUT_STATE[0];
  endproperty
  a_dig5_off: assert property (p_dig5_off) else $error("input five not idle");
  property p_dig6_on;
    (DIG_INPUT_USED[1] && !RESISTIVE_TERMINAL_FIVE_N) [*8] |-> DIG_INPUT_STATE[1];
  endproperty
  a_dig6_on: assert property (p_dig6_on) else $error("input six not active");
  property p_seven_on;
    (DIG_INPUT_USED[2] && MEAS_SEVEN_MV > `AIM_SEVEN_ON_MV) [*3] |-> DIG_INPUT_STATE[2];
  endproperty
  a_seven_on: assert property (p_seven_on) else $error("input seven not active");
  property p_seven_off;
    (DIG_INPUT_USED[2] && MEAS_SEVEN_MV < `AIM_SEVEN_OFF_MV) [*3] |-> !DIG_INPUT_STATE[2];
  endproperty
  a_seven_off: assert property (p_seven_off) else $error("input seven not idle");
  property p_seven_hold;
    (DIG_INPUT_USED[2] && MEAS_SEVEN_MV >= `AIM_SEVEN_OFF_MV && MEAS_SEVEN_MV <= `AIM_SEVEN_ON_MV) [*4]
      |-> $stable(DIG_INPUT_STATE[2]);
  endproperty
  a_seven_hold: assert property (p_seven_hold) else $error("input seven moved in band");
endmodule : aim_props

bind aim_monitor aim_props i_props (
  .REF_CLK, .RSTN, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
  .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID,
  .S_AXI_RREADY, .MEAS_SEVEN_MV, .RESISTIVE_TERMINAL_FOUR_N, .RESISTIVE_TERMINAL_FIVE_N,
  .DIG_INPUT_STATE, .DIG_INPUT_USED
);

`default_nettype wire
